// ===== design/caa_top.sv
// Alarm aggregator: sticky event flags, mask, summary bit, status pin select.
// Assumes events and config port synchronous to ref_clk; read data next cycle.
`default_nettype none
module caa_top
  import caa_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  // Configuration port
  input wire caa_cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  // Event inputs
  input wire caa_events_t events,
  // Status pin routing
  input wire logic summary_pin_select,
  output logic calibration_status_pin,
  output logic alarm_summary
);
  // ==========================================================
  // Decode
  logic [7:0] event_source_flags;
  logic [7:0] event_mask_bits;
  logic [LANES-1:0] per_lane_fifo_flags;
  logic summary;
  wire wr_source = cfg_req.wr && (cfg_req.addr == ADDR_SOURCE);
  wire wr_mask = cfg_req.wr && (cfg_req.addr == ADDR_MASK);
  wire wr_lane = cfg_req.wr && (cfg_req.addr == ADDR_LANE);
  wire [7:0] src_clear = wr_source ? (cfg_req.wdata & FLAG_MASK) : 8'h00;
  wire fifo_clear_all = wr_source && cfg_req.wdata[BIT_FIFO];
  // ==========================================================
  // Set conditions
  wire any_lane_err = |events.lane_fifo_err;
  wire link_set_8b = events.link_enabled && !events.in_data_state;
  wire link_set_64b = events.link_startup || events.realign_event;
  wire link_set = events.mode_64b66b ? link_set_64b : link_set_8b;
  wire [7:0] src_set = {2'b00, any_lane_err, !events.pll_locked, link_set,
                        events.sysref_realign, 1'b0, events.divider_mismatch};
  // Set wins over clear
  wire [7:0] next_source = (event_source_flags & ~src_clear) | src_set;
  wire [LANES-1:0] lane_clr = fifo_clear_all ? {LANES{1'b1}} :
                              (wr_lane ? cfg_req.wdata : {LANES{1'b0}});
  wire [7:0] next_mask = wr_mask ? cfg_req.wdata : event_mask_bits;
  wire next_summary = |(next_source & ~next_mask & FLAG_MASK);
  wire [7:0] next_rdata = (cfg_req.addr == ADDR_SUMMARY) ? {7'h00, summary} :
                          (cfg_req.addr == ADDR_SOURCE) ? event_source_flags :
                          (cfg_req.addr == ADDR_MASK) ? event_mask_bits :
                          (cfg_req.addr == ADDR_LANE) ? per_lane_fifo_flags : 8'h00;
  // ==========================================================
  // Flag registers; flags before link enable are not trusted by software
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_reset) begin
      event_source_flags <= SOURCE_RESET;
      event_mask_bits <= MASK_RESET;
    end else begin
      event_source_flags <= next_source;
      event_mask_bits <= next_mask;
    end
  end
  genvar i;
  generate
    for (i = 0; i < LANES; i++) begin : g_lane
      always_ff @(posedge ref_clk) begin
        if (!rst_n || soft_reset) begin
          per_lane_fifo_flags[i] <= LANE_RESET[i];
        end else begin
          per_lane_fifo_flags[i] <= (per_lane_fifo_flags[i] & ~lane_clr[i]) |
                                    events.lane_fifo_err[i];
        end
      end
    end
  endgenerate
  // ==========================================================
  // Summary and outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_n || soft_reset) begin
      summary <= 1'b0;
      alarm_summary <= 1'b0;
      calibration_status_pin <= 1'b0;
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      summary <= next_summary;
      alarm_summary <= next_summary;
      calibration_status_pin <= summary_pin_select && next_summary;
      cfg_rdata <= next_rdata;
      cfg_rvalid <= cfg_req.rd;
    end
  end
  // ==========================================================
  // Assertions: summary and status pin

  a_summary_value: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    summary == |(event_source_flags & ~event_mask_bits & FLAG_MASK))
    else $error("summary mismatch");

  a_summary_output: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    alarm_summary == summary)
    else $error("summary output mismatch");

  a_pin_route: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    calibration_status_pin == ($past(summary_pin_select) && summary))
    else $error("status pin mismatch");

  a_pin_unselected: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    !summary_pin_select |=> !calibration_status_pin)
    else $error("status pin high while unselected");

  a_masked_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    ((event_mask_bits & FLAG_MASK) == FLAG_MASK) |-> !summary)
    else $error("masked flag reached summary");

  // ==========================================================
  // Assertions: flag setting

  a_fifo_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    any_lane_err |=> event_source_flags[BIT_FIFO])
    else $error("fifo flag not set");

  a_pll_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    !events.pll_locked |=> event_source_flags[BIT_PLL])
    else $error("pll flag not set");

  a_pll_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (events.pll_locked && wr_source && cfg_req.wdata[BIT_PLL]) |=> !event_source_flags[BIT_PLL])
    else $error("pll flag set while locked");

  a_link_8b: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (!events.mode_64b66b && link_set_8b) |=> event_source_flags[BIT_LINK])
    else $error("link flag not set");

  a_link_8b_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (!events.mode_64b66b && !link_set_8b && wr_source && cfg_req.wdata[BIT_LINK])
      |=> !event_source_flags[BIT_LINK])
    else $error("link flag set in data state");

  a_link_64b: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (events.mode_64b66b && link_set_64b) |=> event_source_flags[BIT_LINK])
    else $error("link 64b flag not set");

  a_link_64b_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (events.mode_64b66b && !link_set_64b && wr_source && cfg_req.wdata[BIT_LINK])
      |=> !event_source_flags[BIT_LINK])
    else $error("link 64b flag set without event");

  a_realign_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    events.sysref_realign |=> event_source_flags[BIT_REALIGN])
    else $error("realign flag not set");

  a_realign_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (!events.sysref_realign && wr_source && cfg_req.wdata[BIT_REALIGN])
      |=> !event_source_flags[BIT_REALIGN])
    else $error("realign flag set without event");

  a_clk_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    events.divider_mismatch |=> event_source_flags[BIT_CLK])
    else $error("clock flag not set");

  a_clk_quiet: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (!events.divider_mismatch && wr_source && cfg_req.wdata[BIT_CLK])
      |=> !event_source_flags[BIT_CLK])
    else $error("clock flag set without mismatch");

  // ==========================================================
  // Assertions: clearing, priority and reset

  a_clear_one: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (wr_source && (src_set == 8'h00))
      |=> ((event_source_flags & $past(cfg_req.wdata) & FLAG_MASK) == 8'h00))
    else $error("clear failed");

  a_keep_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    wr_source |=> ((event_source_flags & ~$past(cfg_req.wdata) & FLAG_MASK) ==
                   (($past(event_source_flags) | $past(src_set)) & ~$past(cfg_req.wdata) &
                    FLAG_MASK)))
    else $error("flag lost");

  a_flag_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    !wr_source |=> event_source_flags == ($past(event_source_flags) | $past(src_set)))
    else $error("flag changed without write");

  a_set_wins: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (wr_source && (src_set != 8'h00)) |=> ((event_source_flags & $past(src_set)) == $past(src_set)))
    else $error("clear beat a set");

  a_reset_value: assert property (
    @(posedge ref_clk)
    (!rst_n || soft_reset) |=> event_source_flags == SOURCE_RESET)
    else $error("reset value wrong");

  a_reserved_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    event_source_flags[7:6] == 2'b00)
    else $error("reserved flag bits set");

  a_reset_mask: assert property (
    @(posedge ref_clk)
    (!rst_n || soft_reset) |=> event_mask_bits == MASK_RESET)
    else $error("mask reset value wrong");

  a_reset_outputs: assert property (
    @(posedge ref_clk)
    (!rst_n || soft_reset) |=> (!summary && !alarm_summary && !calibration_status_pin))
    else $error("outputs not cleared by reset");

  a_mask_write: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    wr_mask |=> event_mask_bits == $past(cfg_req.wdata))
    else $error("mask write lost");

  a_mask_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    !wr_mask |=> $stable(event_mask_bits))
    else $error("mask changed without write");

  // ==========================================================
  // Assertions: lane register

  a_lane_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (fifo_clear_all && !any_lane_err) |=> per_lane_fifo_flags == 8'h00)
    else $error("lane clear failed");

  a_lane_set: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    any_lane_err |=> ((per_lane_fifo_flags & $past(events.lane_fifo_err)) ==
                      $past(events.lane_fifo_err)))
    else $error("lane flag not set");

  a_lane_write_clear: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (wr_lane && !any_lane_err) |=> ((per_lane_fifo_flags & $past(cfg_req.wdata)) == 8'h00))
    else $error("lane write clear failed");

  a_lane_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (!fifo_clear_all && !wr_lane)
      |=> per_lane_fifo_flags == ($past(per_lane_fifo_flags) | $past(events.lane_fifo_err)))
    else $error("lane flag changed without write");

  a_reset_lane: assert property (
    @(posedge ref_clk)
    (!rst_n || soft_reset) |=> per_lane_fifo_flags == LANE_RESET)
    else $error("lane reset value wrong");

  // ==========================================================
  // Assertions: configuration port

  a_reserved_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.rd && cfg_req.addr == ADDR_SUMMARY) |=> cfg_rdata[7:1] == 7'h00)
    else $error("reserved bits set");

  a_read_summary: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.rd && cfg_req.addr == ADDR_SUMMARY) |=> cfg_rdata[0] == $past(summary))
    else $error("summary read wrong");

  a_summary_write_ignored: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.wr && cfg_req.addr == ADDR_SUMMARY && src_set == 8'h00)
      |=> (event_source_flags == $past(event_source_flags) &&
           event_mask_bits == $past(event_mask_bits)))
    else $error("summary write had effect");

  a_read_source: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.rd && cfg_req.addr == ADDR_SOURCE) |=> cfg_rdata == $past(event_source_flags))
    else $error("source read wrong");

  a_read_lane: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.rd && cfg_req.addr == ADDR_LANE) |=> cfg_rdata == $past(per_lane_fifo_flags))
    else $error("lane read wrong");

  a_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    (cfg_req.rd && cfg_req.addr != ADDR_SUMMARY && cfg_req.addr != ADDR_SOURCE &&
     cfg_req.addr != ADDR_MASK && cfg_req.addr != ADDR_LANE) |=> cfg_rdata == 8'h00)
    else $error("unmapped read not zero");

  a_rvalid_high: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    cfg_req.rd |=> cfg_rvalid)
    else $error("read valid missing");

  a_rvalid_low: assert property (
    @(posedge ref_clk) disable iff (!rst_n || soft_reset)
    !cfg_req.rd |=> !cfg_rvalid)
    else $error("read valid without read");

  // ==========================================================
  // Covers
  c_alarm_rise: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(summary));
  c_clear_all: cover property (@(posedge ref_clk) disable iff (!rst_n)
    wr_source ##1 (event_source_flags & FLAG_MASK) == 8'h00);
  c_pin_high: cover property (@(posedge ref_clk) disable iff (!rst_n) calibration_status_pin);
  c_set_wins: cover property (@(posedge ref_clk) disable iff (!rst_n)
    wr_source && (src_set & cfg_req.wdata) != 8'h00);
  c_lane_error: cover property (@(posedge ref_clk) disable iff (!rst_n)
    wr_lane ##1 per_lane_fifo_flags == 8'h00 ##1 per_lane_fifo_flags != 8'h00);
endmodule
`default_nettype wire

// ===== common/caa_pkg.sv
// Package for the converter alarm aggregator: register map, fields, resets.
// Assumes an 8-bit configuration port with a 12-bit register address.
`default_nettype none
package caa_pkg;
  localparam logic [11:0] ADDR_SUMMARY = 12'h2c0;
  localparam logic [11:0] ADDR_SOURCE = 12'h2c1;
  localparam logic [11:0] ADDR_MASK = 12'h2c2;
  localparam logic [11:0] ADDR_LANE = 12'h2c4;
  localparam int BIT_FIFO = 5;
  localparam int BIT_PLL = 4;
  localparam int BIT_LINK = 3;
  localparam int BIT_REALIGN = 2;
  localparam int BIT_CLK = 0;
  localparam logic [7:0] FLAG_MASK = 8'h3d;
  localparam logic [7:0] SOURCE_RESET = 8'h3f;
  localparam logic [7:0] MASK_RESET = 8'h3f;
  localparam logic [7:0] LANE_RESET = 8'hff;
  localparam int LANES = 8;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } caa_cfg_req_t;
  typedef struct packed {
    logic [LANES-1:0] lane_fifo_err;
    logic pll_locked;
    logic link_enabled;
    logic in_data_state;
    logic mode_64b66b;
    logic link_startup;
    logic realign_event;
    logic sysref_realign;
    logic divider_mismatch;
  } caa_events_t;
endpackage
`default_nettype wire

// ===== bench/tb_converter_alarm_aggregator.sv
// Self-checking bench for the alarm aggregator top.
// Assumes caa_pkg; drives every input port except ref_clk on the falling clock edge.
`default_nettype none
module tb_converter_alarm_aggregator
  import caa_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic summary_pin_select = 1'b1;
  caa_cfg_req_t cfg_req = '0;
  caa_events_t ev = '{lane_fifo_err: '0, pll_locked: 1'b1, default: 1'b0};
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  logic calibration_status_pin;
  logic alarm_summary;
  int miscompares = 0;
  int total_checks = 0;
  caa_top caa_top_i (.ref_clk(ref_clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .cfg_req(cfg_req), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .events(ev),
    .summary_pin_select(summary_pin_select), .calibration_status_pin(calibration_status_pin),
    .alarm_summary(alarm_summary));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Port tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cfg_req = '{1'b1, 1'b0, a, d};
    @(negedge ref_clk);
    cfg_req = '0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] m, input logic [7:0] exp,
                    input string what);
    cfg_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge ref_clk);
    chk({what, " valid"}, 8'h01, {7'h00, cfg_rvalid});
    chk(what, exp, cfg_rdata & m);
    cfg_req = '0;
    @(negedge ref_clk);
  endtask
  // Keep the mode in step with the link events
  task automatic set_ev(input int k, input logic v);
    ev.mode_64b66b = v && (k == 3 || k == 4);
    case (k)
      0: ev.lane_fifo_err[3] = v;
      1: ev.pll_locked = !v;
      2: ev.link_enabled = v;
      3: ev.link_startup = v;
      4: ev.realign_event = v;
      5: ev.sysref_realign = v;
      default: ev.divider_mismatch = v;
    endcase
  endtask
  // ==========================================
  // Scenarios
  task automatic t_reset;
    rd(ADDR_SOURCE, FLAG_MASK, 8'h3d, "source reset");
    rd(ADDR_MASK, 8'hff, MASK_RESET, "mask reset");
    rd(ADDR_LANE, 8'hff, LANE_RESET, "lane reset");
    wr(ADDR_SUMMARY, 8'hff);
    rd(ADDR_SUMMARY, 8'hff, 8'h00, "summary ro");
    rd(12'h2c3, 8'hff, 8'h00, "unmapped");
    $display("test reset done");
  endtask
  task automatic t_events;
    int bits[7] = '{5, 4, 3, 3, 3, 2, 0};
    for (int k = 0; k < 7; k++) begin
      wr(ADDR_SOURCE, 8'hff);
      wr(ADDR_MASK, 8'h02);
      rd(ADDR_SOURCE, FLAG_MASK, 8'h00, "cleared");
      set_ev(k, 1'b1);
      @(negedge ref_clk);
      set_ev(k, 1'b0);
      chk("pins", 8'h03, {6'h00, calibration_status_pin, alarm_summary});
      rd(ADDR_SOURCE, FLAG_MASK, 8'h01 << bits[k], "flag");
      rd(ADDR_SUMMARY, 8'hff, 8'h01, "summary");
      wr(ADDR_MASK, 8'h02 | (8'h01 << bits[k]));
      rd(ADDR_SUMMARY, 8'hff, 8'h00, "masked");
    end
    wr(ADDR_MASK, 8'h02);
    summary_pin_select = 1'b0;
    @(negedge ref_clk);
    chk("pin off", 8'h01, {6'h00, calibration_status_pin, alarm_summary});
    summary_pin_select = 1'b1;
    $display("test events done");
  endtask
  task automatic t_lane_priority;
    wr(ADDR_LANE, 8'hff);
    set_ev(0, 1'b1);
    @(negedge ref_clk);
    set_ev(0, 1'b0);
    rd(ADDR_LANE, 8'hff, 8'h08, "lane bit");
    wr(ADDR_SOURCE, 8'h20);
    rd(ADDR_LANE, 8'hff, 8'h00, "lane cleared");
    set_ev(1, 1'b1);
    wr(ADDR_SOURCE, 8'h10);
    rd(ADDR_SOURCE, 8'h10, 8'h10, "set wins");
    set_ev(1, 1'b0);
    wr(ADDR_SOURCE, 8'h10);
    rd(ADDR_SOURCE, 8'h10, 8'h00, "clear after");
    $display("test lane priority done");
  endtask
  task automatic t_soft;
    soft_reset = 1'b1;
    @(negedge ref_clk);
    soft_reset = 1'b0;
    rd(ADDR_SOURCE, FLAG_MASK, 8'h3d, "soft source");
    rd(ADDR_MASK, 8'hff, MASK_RESET, "soft mask");
    $display("test soft reset done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    t_reset();
    t_events();
    t_lane_priority();
    t_soft();
    stop_test();
  end
endmodule
`default_nettype wire
